/* File: dv/dpllrc_control_tb_top.sv */
module dpllrc_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                     core_clk   = 1'b0;
    logic                     rst_n      = 1'b0;
    logic [15:0]              regAddr    = 16'h0000;
    logic [15:0]              regWrData  = 16'h0000;
    logic                     regWrStb   = 1'b0;
    logic                     regRdStb   = 1'b0;
    logic [15:0]              regRdData;
    dpllrc_pkg::dpllrc_ctrl_s ctrl;
    dpllrc_pkg::dpllrc_sel_s  sel;
    int                       mismatches = 0;
    int                       n_compared = 0;
    logic [15:0]              d;
    logic [2:0]               pm;
    always #50 core_clk = ~core_clk;
    dpllrc_control dut (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .ctrl(ctrl), .sel(sel));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // each bus task ends 1 ns past the sampling edge so results have landed
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        regAddr <= a;
        regWrData <= v;
        regWrStb <= 1'b1;
        @(posedge core_clk);
        regWrStb <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge core_clk);
        regRdStb <= 1'b0;
        #1;
        check(regRdData, exp);
    endtask : rd
    task automatic final_report;
        if (mismatches == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    initial begin
        #100000;
        mismatches++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        check(16'(ctrl), 16'h0000);
        check(16'(sel), 16'h0800);
        rd(dpllrc_pkg::REF_SWITCH_CTRL_ADDR, dpllrc_pkg::REF_SWITCH_CTRL_RESET);
        for (logic [3:0] k = 4'h0; k < 4'h8; k++) begin
            // upper byte set on purpose: it must be dropped
            d = {8'hFF, k[0], k[1:0] ^ 2'h2, k[2:0], k[2:1]};
            pm = d[4:2];
            wr(dpllrc_pkg::REF_SWITCH_CTRL_ADDR, d);
            check(16'(ctrl), {8'h00, d[7:0]});
            check(16'(sel.applyOffset), 16'(!d[7]));
            check(16'(sel.alignNearest), 16'(d[7]));
            check(16'(sel.forceRef), 16'(pm >= 3'h2 && pm <= 3'h5));
            check(16'(sel.badMode), 16'(pm >= 3'h6));
            if (pm >= 3'h2 && pm <= 3'h5) check(16'(sel.forcedRef), 16'(pm - 3'h2));
            check(16'(sel.usePreferred), 16'(pm == 3'h1));
            if (pm == 3'h1) check(16'(sel.preferredRef), 16'(d[6:5]));
            check(16'(sel.pairOnly), 16'(pm == 3'h1 && d[1:0] == 2'h0));
            check(16'(sel.dpllMode), 16'(d[1:0]));
            rd(dpllrc_pkg::REF_SWITCH_CTRL_ADDR, {8'h00, d[7:0]});
        end
        wr(16'h004C, 16'h0000);
        check(16'(ctrl), {8'h00, d[7:0]});
        rd(16'h004C, 16'h0000);
        // preferred mode outside automatic must not pair
        wr(dpllrc_pkg::REF_SWITCH_CTRL_ADDR, 16'h0025);
        check(16'(sel.pairOnly), 16'h0000);
        check(16'(sel.preferredRef), 16'h0001);
        check(16'(sel.dpllMode), 16'(dpllrc_pkg::DPLLRC_NORMAL));
        rd(dpllrc_pkg::REF_SWITCH_CTRL_ADDR, 16'h0025);
        wr(dpllrc_pkg::REF_SWITCH_CTRL_ADDR, 16'h0044);
        check(16'(sel.pairOnly), 16'h0001);
        check(16'(sel.preferredRef), 16'h0002);
        wr(dpllrc_pkg::REF_SWITCH_CTRL_ADDR, 16'h0005);
        check(16'(sel.preferredRef), 16'h0000);
        final_report();
    end
endmodule : dpllrc_control_tb_top

/* File: rtl/dpllrc_control.sv */
// Operation
// - While the offset reset bit is low, the phase offset between reference and output is applied and held.
// - While the offset reset bit is high, the offset is held reset at zero and outputs align to the nearest edge.
// - Preference mode bits 4..2 decode as none, preferred, force ref 0..3, with 110 and 111 reserved.
// - Preferred reference bits 6..5 are used only when preference mode is 001.
// - Forced mode 00 is automatic, and with preference mode 001 gives automatic switching with preference.
// - Automatic switching with preference alternates between two references only.
// - Bits 1..0 force the DPLL into automatic, normal, holdover or freerun.
module dpllrc_control (
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    input  wire logic [15:0]           regAddr,
    input  wire logic [15:0]           regWrData,
    input  wire logic                  regWrStb,
    input  wire logic                  regRdStb,
    output logic [15:0]                regRdData,
    output dpllrc_pkg::dpllrc_ctrl_s   ctrl,
    output dpllrc_pkg::dpllrc_sel_s    sel
);
    dpllrc_pkg::dpllrc_ctrl_s next_ctrl;
    dpllrc_pkg::dpllrc_sel_s  next_sel;
    logic                     ctrlHit;

    assign ctrlHit = (regAddr == dpllrc_pkg::REF_SWITCH_CTRL_ADDR);

    always_comb begin
        next_ctrl = ctrl;
        if (regWrStb && ctrlHit) begin
            next_ctrl = dpllrc_pkg::dpllrc_ctrl_s'(regWrData[7:0]);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= dpllrc_pkg::dpllrc_ctrl_s'(dpllrc_pkg::REF_SWITCH_CTRL_RESET[7:0]);
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // unmapped addresses read zero; upper bits are reserved zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= 16'h0000;
        end else if (regRdStb && ctrlHit) begin
            regRdData <= {8'h00, ctrl} & dpllrc_pkg::CTRL_WRITE_MASK;
        end else begin
            regRdData <= 16'h0000;
        end
    end

    always_comb begin
        next_sel = '0;
        next_sel.applyOffset  = !next_ctrl.offsetReset;
        next_sel.alignNearest = next_ctrl.offsetReset;
        unique case (next_ctrl.prefMode)
            3'h0: ;
            3'h1: begin
                next_sel.usePreferred = 1'b1;
                next_sel.preferredRef = next_ctrl.prefRef;
            end
            3'h2, 3'h3, 3'h4, 3'h5: begin
                next_sel.forceRef  = 1'b1;
                next_sel.forcedRef = 2'(next_ctrl.prefMode - dpllrc_pkg::PMODE_FORCE_TIMING_REF_0);
            end
            default: next_sel.badMode = 1'b1;
        endcase
        next_sel.dpllMode = next_ctrl.forcedMode;
        next_sel.pairOnly = next_sel.usePreferred &&
                            (next_ctrl.forcedMode == dpllrc_pkg::DPLLRC_AUTO);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel <= '{
                applyOffset:  1'b1,
                alignNearest: 1'b0,
                forceRef:     1'b0,
                forcedRef:    2'h0,
                usePreferred: 1'b0,
                preferredRef: 2'h0,
                pairOnly:     1'b0,
                dpllMode:     dpllrc_pkg::DPLLRC_AUTO,
                badMode:      1'b0
            };
        end else begin
            sel <= next_sel;
        end
    end

    property p_offset;
        @(posedge core_clk) disable iff (!rst_n)
            sel.alignNearest == ctrl.offsetReset && sel.applyOffset != ctrl.offsetReset;
    endproperty
    a_offset: assert property (p_offset) else $error("offset control mismatch");

    property p_pref;
        @(posedge core_clk) disable iff (!rst_n)
            sel.usePreferred |->
            ctrl.prefMode == dpllrc_pkg::PMODE_PREFERRED && sel.preferredRef == ctrl.prefRef;
    endproperty
    a_pref: assert property (p_pref) else $error("preferred ref used outside mode 001");

    property p_force;
        @(posedge core_clk) disable iff (!rst_n)
            sel.forceRef |->
            3'(sel.forcedRef) + 3'h2 == ctrl.prefMode;
    endproperty
    a_force: assert property (p_force) else $error("forced reference wrong");

    property p_pair;
        @(posedge core_clk) disable iff (!rst_n)
            sel.pairOnly |->
            sel.dpllMode == dpllrc_pkg::DPLLRC_AUTO && sel.usePreferred;
    endproperty
    a_pair: assert property (p_pair) else $error("pair mode outside auto preferred");

    property p_mode;
        @(posedge core_clk) disable iff (!rst_n)
            regWrStb && ctrlHit |=>
            sel.dpllMode == dpllrc_pkg::dpllrc_mode_e'($past(regWrData[1:0]));
    endproperty
    a_mode: assert property (p_mode) else $error("forced mode not applied");

    property p_reserved;
        @(posedge core_clk) disable iff (!rst_n)
            sel.badMode |->
            !sel.forceRef && !sel.usePreferred && ctrl.prefMode > dpllrc_pkg::PMODE_FORCE_TIMING_REF_3;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code acted on");

    property p_read;
        @(posedge core_clk) disable iff (!rst_n)
            regRdStb && !ctrlHit |=>
            regRdData == 16'h0000;
    endproperty
    a_read: assert property (p_read) else $error("unmapped read not zero");

    property p_readback;
        @(posedge core_clk) disable iff (!rst_n)
            regRdStb && ctrlHit |=>
            regRdData[15:8] == 8'h00 && regRdData[7:0] == $past(ctrl);
    endproperty
    a_readback: assert property (p_readback) else $error("readback mismatch");

    // written fields must reach the selector on the very next edge, raw bits in
    property p_offset_write;
        @(posedge core_clk) disable iff (!rst_n)
            regWrStb && ctrlHit |=>
            sel.alignNearest == $past(regWrData[dpllrc_pkg::OFFSET_RESET_BIT]);
    endproperty
    a_offset_write: assert property (p_offset_write) else $error("offset reset not taken");

    property p_apply_write;
        @(posedge core_clk) disable iff (!rst_n)
            regWrStb && ctrlHit && !regWrData[dpllrc_pkg::OFFSET_RESET_BIT] |=>
            sel.applyOffset && !sel.alignNearest;
    endproperty
    a_apply_write: assert property (p_apply_write) else $error("offset not applied");

    property p_hold;
        @(posedge core_clk) disable iff (!rst_n)
            !(regWrStb && ctrlHit) |=>
            $stable(ctrl) && $stable(sel);
    endproperty
    a_hold: assert property (p_hold) else $error("control changed without write");

    property p_none;
        @(posedge core_clk) disable iff (!rst_n)
            ctrl.prefMode == dpllrc_pkg::PMODE_NONE |->
            !sel.forceRef && !sel.usePreferred && !sel.badMode;
    endproperty
    a_none: assert property (p_none) else $error("no preference acted on");

    property p_reserved_set;
        @(posedge core_clk) disable iff (!rst_n)
            ctrl.prefMode > dpllrc_pkg::PMODE_FORCE_TIMING_REF_3 |->
            sel.badMode;
    endproperty
    a_reserved_set: assert property (p_reserved_set) else $error("reserved code not flagged");

    property p_force_excl;
        @(posedge core_clk) disable iff (!rst_n)
            sel.forceRef |->
            !sel.usePreferred && !sel.badMode && !sel.pairOnly;
    endproperty
    a_force_excl: assert property (p_force_excl) else $error("forced ref with other mode");

    property p_pref_excl;
        @(posedge core_clk) disable iff (!rst_n)
            sel.usePreferred |->
            !sel.forceRef && !sel.badMode;
    endproperty
    a_pref_excl: assert property (p_pref_excl) else $error("preferred with other mode");

    property p_pref_zero;
        @(posedge core_clk) disable iff (!rst_n)
            !sel.usePreferred |->
            sel.preferredRef == 2'h0 && !sel.pairOnly;
    endproperty
    a_pref_zero: assert property (p_pref_zero) else $error("preferred field leaked");

    property p_auto_pair;
        @(posedge core_clk) disable iff (!rst_n)
            ctrl.prefMode == dpllrc_pkg::PMODE_PREFERRED && ctrl.forcedMode == dpllrc_pkg::DPLLRC_AUTO |->
            sel.pairOnly;
    endproperty
    a_auto_pair: assert property (p_auto_pair) else $error("auto preferred not paired");

    property p_pair_off;
        @(posedge core_clk) disable iff (!rst_n)
            ctrl.forcedMode != dpllrc_pkg::DPLLRC_AUTO |->
            !sel.pairOnly;
    endproperty
    a_pair_off: assert property (p_pair_off) else $error("pairing outside auto");

    property p_pair_pref;
        @(posedge core_clk) disable iff (!rst_n)
            sel.pairOnly |->
            sel.preferredRef == ctrl.prefRef;
    endproperty
    a_pair_pref: assert property (p_pair_pref) else $error("pairing lost preferred ref");

    property p_force_mode;
        @(posedge core_clk) disable iff (!rst_n)
            sel.forceRef |->
            sel.dpllMode == ctrl.forcedMode;
    endproperty
    a_force_mode: assert property (p_force_mode) else $error("forced ref disturbed mode");

    property p_pref_write;
        @(posedge core_clk) disable iff (!rst_n)
            regWrStb && ctrlHit && regWrData[dpllrc_pkg::PREF_MODE_LSB +: 3] == dpllrc_pkg::PMODE_PREFERRED |=>
            sel.usePreferred && sel.preferredRef == $past(regWrData[dpllrc_pkg::PREF_REF_LSB +: 2]);
    endproperty
    a_pref_write: assert property (p_pref_write) else $error("preferred write not taken");

    property p_reserved_write;
        @(posedge core_clk) disable iff (!rst_n)
            regWrStb && ctrlHit && regWrData[dpllrc_pkg::PREF_MODE_LSB +: 3] > dpllrc_pkg::PMODE_FORCE_TIMING_REF_3 |=>
            sel.badMode && !sel.forceRef;
    endproperty
    a_reserved_write: assert property (p_reserved_write) else $error("reserved write acted on");

    property p_mode_auto;
        @(posedge core_clk) disable iff (!rst_n)
            regWrStb && ctrlHit && regWrData[dpllrc_pkg::FORCED_MODE_LSB +: 2] == 2'h0 |=>
            sel.dpllMode == dpllrc_pkg::DPLLRC_AUTO;
    endproperty
    a_mode_auto: assert property (p_mode_auto) else $error("code 00 not automatic");

    property p_mode_normal;
        @(posedge core_clk) disable iff (!rst_n)
            regWrStb && ctrlHit && regWrData[dpllrc_pkg::FORCED_MODE_LSB +: 2] == 2'h1 |=>
            sel.dpllMode == dpllrc_pkg::DPLLRC_NORMAL;
    endproperty
    a_mode_normal: assert property (p_mode_normal) else $error("code 01 not normal");

    property p_mode_holdover;
        @(posedge core_clk) disable iff (!rst_n)
            regWrStb && ctrlHit && regWrData[dpllrc_pkg::FORCED_MODE_LSB +: 2] == 2'h2 |=>
            sel.dpllMode == dpllrc_pkg::DPLLRC_HOLDOVER;
    endproperty
    a_mode_holdover: assert property (p_mode_holdover) else $error("code 10 not holdover");

    property p_mode_freerun;
        @(posedge core_clk) disable iff (!rst_n)
            regWrStb && ctrlHit && regWrData[dpllrc_pkg::FORCED_MODE_LSB +: 2] == 2'h3 |=>
            sel.dpllMode == dpllrc_pkg::DPLLRC_FREERUN;
    endproperty
    a_mode_freerun: assert property (p_mode_freerun) else $error("code 11 not freerun");

    property p_write_low;
        @(posedge core_clk) disable iff (!rst_n)
            regWrStb && ctrlHit |=>
            ctrl == $past(regWrData[7:0]);
    endproperty
    a_write_low: assert property (p_write_low) else $error("low byte not stored");

    property p_other_addr;
        @(posedge core_clk) disable iff (!rst_n)
            regWrStb && !ctrlHit |=>
            $stable(ctrl);
    endproperty
    a_other_addr: assert property (p_other_addr) else $error("unmapped write changed control");

    property p_read_only_after;
        @(posedge core_clk) disable iff (!rst_n)
            regRdData != 16'h0000 |->
            $past(regRdStb && ctrlHit);
    endproperty
    a_read_only_after: assert property (p_read_only_after) else $error("read data without read");

    property p_read_idle;
        @(posedge core_clk) disable iff (!rst_n)
            !regRdStb |=>
            regRdData == 16'h0000;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data stood too long");

    property p_read_upper;
        @(posedge core_clk) disable iff (!rst_n)
            regRdData[15:8] == 8'h00;
    endproperty
    a_read_upper: assert property (p_read_upper) else $error("reserved read bits set");

    // per-reference decode, one copy per timing reference
    for (genvar i = 0; i < 4; i++) begin : g_ref
        property p_ref_force;
            @(posedge core_clk) disable iff (!rst_n)
                ctrl.prefMode == dpllrc_pkg::PMODE_FORCE_TIMING_REF_0 + 3'(i) |->
                sel.forceRef && sel.forcedRef == 2'(i);
        endproperty
        a_ref_force: assert property (p_ref_force) else $error("forced reference decode wrong");

        property p_ref_pref;
            @(posedge core_clk) disable iff (!rst_n)
                ctrl.prefMode == dpllrc_pkg::PMODE_PREFERRED && ctrl.prefRef == 2'(i) |->
                sel.usePreferred && sel.preferredRef == 2'(i);
        endproperty
        a_ref_pref: assert property (p_ref_pref) else $error("preferred reference decode wrong");
    end

    c_pair: cover property (@(posedge core_clk) disable iff (!rst_n) sel.pairOnly);
    c_force: cover property (@(posedge core_clk) disable iff (!rst_n) sel.forceRef && sel.dpllMode == dpllrc_pkg::DPLLRC_HOLDOVER);
    c_align: cover property (@(posedge core_clk) disable iff (!rst_n) sel.alignNearest);
    c_reserved: cover property (@(posedge core_clk) disable iff (!rst_n) sel.badMode);
    c_readback: cover property (@(posedge core_clk) disable iff (!rst_n) regRdData != 16'h0000);
endmodule : dpllrc_control

/* File: rtl/dpllrc_pkg.sv */
package dpllrc_pkg;
    localparam logic [15:0] REF_SWITCH_CTRL_ADDR  = 16'h004B;
    localparam logic [15:0] REF_SWITCH_CTRL_RESET = 16'h0000;
    localparam int          FORCED_MODE_LSB       = 0;
    localparam int          PREF_MODE_LSB         = 2;
    localparam int          PREF_REF_LSB          = 5;
    localparam int          OFFSET_RESET_BIT      = 7;
    localparam logic [15:0] CTRL_WRITE_MASK       = 16'h00FF;

    localparam logic [2:0]  PMODE_NONE            = 3'h0;
    localparam logic [2:0]  PMODE_PREFERRED       = 3'h1;
    localparam logic [2:0]  PMODE_FORCE_TIMING_REF_0      = 3'h2;
    localparam logic [2:0]  PMODE_FORCE_TIMING_REF_3      = 3'h5;

    typedef enum logic [1:0] {
        DPLLRC_AUTO,
        DPLLRC_NORMAL,
        DPLLRC_HOLDOVER,
        DPLLRC_FREERUN
    } dpllrc_mode_e;

    typedef struct packed {
        logic         offsetReset;
        logic [1:0]   prefRef;
        logic [2:0]   prefMode;
        dpllrc_mode_e forcedMode;
    } dpllrc_ctrl_s;

    typedef struct packed {
        logic         applyOffset;
        logic         alignNearest;
        logic         forceRef;
        logic [1:0]   forcedRef;
        logic         usePreferred;
        logic [1:0]   preferredRef;
        logic         pairOnly;
        dpllrc_mode_e dpllMode;
        logic         badMode;
    } dpllrc_sel_s;
endpackage : dpllrc_pkg
